//--- srsp_pkg.sv
// Operation
// - Device is slave only, never drives clock
// - Host frames each transaction with select low
// - Device samples input on rising clock edge
// - Device shifts output on falling clock edge
// - Host captures output on rising edges
// - Output stays released until read requested
// - Drive output only after read direction bit
// - All bytes and words go MSB first
// - Header: seven address bits then direction bit
// - Direction one writes, zero reads
// - Words travel upper byte then lower byte
// - Mode three: clock idles high
// - Host holds clock high when idle
// - Host clock no faster than 10 MHz
// - Address increments except 0x5f, 0x60, 0x7f
// - Each FIFO read advances FIFO one word
package srsp_pkg;
   localparam int SRSP_ADDR_W = 7;
   localparam int SRSP_DATA_W = 16;
   localparam int SRSP_HDR_BITS = 8;
   localparam logic [6:0] SRSP_ADDR_HOLD_A = 7'h5f;
   localparam logic [6:0] SRSP_ADDR_FIFO = 7'h60;
   localparam logic [6:0] SRSP_ADDR_HOLD_B = 7'h7f;
   localparam logic SRSP_DIR_WRITE = 1'b1;
   localparam logic SRSP_DIR_READ = 1'b0;
   localparam int SRSP_CLK_MHZ = 50;
   localparam int SRSP_SCLK_MAX_MHZ = 10;
   // Half period of the host-made clock, in system cycles, rounded up to stay under max rate
   localparam int SRSP_SCLK_HALF_CYC =
      (SRSP_CLK_MHZ + 2 * SRSP_SCLK_MAX_MHZ - 1) / (2 * SRSP_SCLK_MAX_MHZ);
   // A reply bit needs six cycles from a host falling edge: two synchroniser stages and
   // one register in the device, then two synchroniser stages in the host
   localparam int SRSP_LOOP_CYC = 6;
   localparam int SRSP_HALF_MIN =
      (SRSP_SCLK_HALF_CYC > SRSP_LOOP_CYC) ? SRSP_SCLK_HALF_CYC : SRSP_LOOP_CYC;
   // Divider reload value; the toggle itself costs one more cycle
   localparam logic [7:0] SRSP_HALF_CNT = 8'(SRSP_HALF_MIN - 1);

   typedef enum logic [1:0] {
      SRSP_H_IDLE = 2'b00,
      SRSP_H_SHIFT = 2'b01,
      SRSP_H_GAP = 2'b10
   } srsp_hstate_e;

   // Address after a word: hold at the special locations
   function automatic logic [6:0] srsp_next_addr(input logic [6:0] a);
      if (a == SRSP_ADDR_HOLD_A || a == SRSP_ADDR_FIFO || a == SRSP_ADDR_HOLD_B) begin
         return a;
      end
      return a + 7'h01;
   endfunction : srsp_next_addr
endpackage : srsp_pkg

//--- srsp_if.sv
`timescale 1ns/100ps
interface srsp_if;
   logic cs_n;
   logic sclk;
   logic mosi;
   logic miso_o;
   logic miso_oe_n;
   // Released line reads high, as through a pull-up
   wire miso = miso_oe_n ? 1'b1 : miso_o;
   modport dev (input cs_n, input sclk, input mosi, output miso_o, output miso_oe_n);
   modport host (output cs_n, output sclk, output mosi, input miso);
endinterface : srsp_if

//--- srsp_dev.sv
`timescale 1ns/100ps
module srsp_dev
   import srsp_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   srsp_if.dev link,
   output logic [6:0] reg_addr,
   output logic wr_stb,
   output logic [15:0] wr_data,
   output logic rd_stb,
   output logic fifo_pop,
   input wire logic [15:0] rd_data
);
   // ==========================================
   // Pin synchronisers
   logic [1:0] cs_s, ck_s, mo_s;
   logic ck_d;
   logic [1:0] next_cs_s, next_ck_s, next_mo_s;
   always_comb begin
      next_cs_s = {cs_s[0], link.cs_n};
      next_ck_s = {ck_s[0], link.sclk};
      next_mo_s = {mo_s[0], link.mosi};
   end
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cs_s <= 2'h3;
         ck_s <= 2'h3;
         mo_s <= 2'h0;
         ck_d <= 1'b1;
      end else begin
         cs_s <= next_cs_s;
         ck_s <= next_ck_s;
         mo_s <= next_mo_s;
         ck_d <= ck_s[1];
      end
   end
   wire sel = !cs_s[1];
   wire rise = sel && ck_s[1] && !ck_d;
   wire fall = sel && !ck_s[1] && ck_d;

   // ==========================================
   // Shift engine; clock is only ever an input here
   logic [3:0] bcnt, next_bcnt;
   logic hdr_done, next_hdr_done;
   logic dir, next_dir;
   logic [15:0] sh_in, next_sh_in;
   logic [15:0] sh_out, next_sh_out;
   logic [6:0] next_reg_addr;
   logic next_wr_stb, next_rd_stb, next_fifo_pop;
   logic [15:0] next_wr_data;
   logic miso_o, next_miso_o;
   logic oe_n, next_oe_n;
   logic load, next_load;

   always_comb begin
      next_bcnt = bcnt;
      next_hdr_done = hdr_done;
      next_dir = dir;
      next_sh_in = sh_in;
      next_sh_out = sh_out;
      next_reg_addr = reg_addr;
      next_wr_stb = 1'b0;
      next_rd_stb = 1'b0;
      next_fifo_pop = 1'b0;
      next_wr_data = wr_data;
      next_miso_o = miso_o;
      next_oe_n = oe_n;
      next_load = 1'b0;
      if (!sel) begin
         // Deselect drops any partial word and releases the line
         next_bcnt = 4'h0;
         next_hdr_done = 1'b0;
         next_oe_n = 1'b1;
      end else begin
         if (load) begin
            // Read data fetched in the same cycle as the request strobe
            next_sh_out = rd_data;
         end
         if (rise) begin
            next_sh_in = {sh_in[14:0], mo_s[1]};
            next_bcnt = bcnt + 4'h1;
            if (!hdr_done && bcnt == 4'h7) begin
               // Header: address MSB first, then direction
               next_reg_addr = sh_in[6:0];
               next_dir = mo_s[1];
               next_hdr_done = 1'b1;
               next_bcnt = 4'h0;
               if (mo_s[1] == SRSP_DIR_READ) begin
                  next_rd_stb = 1'b1;
                  next_load = 1'b1;
               end
            end else if (hdr_done && bcnt == 4'hf) begin
               // Upper byte then lower byte make one word
               if (dir == SRSP_DIR_WRITE) begin
                  next_wr_data = {sh_in[14:0], mo_s[1]};
                  next_wr_stb = 1'b1;
                  next_reg_addr = srsp_next_addr(reg_addr);
               end else begin
                  next_fifo_pop = (reg_addr == SRSP_ADDR_FIFO);
                  next_reg_addr = srsp_next_addr(reg_addr);
                  next_rd_stb = 1'b1;
                  next_load = 1'b1;
               end
            end
         end
         if (fall && hdr_done && dir == SRSP_DIR_READ) begin
            // First falling edge after a read header turns on the driver
            next_oe_n = 1'b0;
            next_miso_o = sh_out[15];
            next_sh_out = {sh_out[14:0], 1'b0};
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         bcnt <= 4'h0;
         hdr_done <= 1'b0;
         dir <= 1'b0;
         sh_in <= 16'h0000;
         sh_out <= 16'h0000;
         reg_addr <= 7'h00;
         wr_stb <= 1'b0;
         rd_stb <= 1'b0;
         fifo_pop <= 1'b0;
         wr_data <= 16'h0000;
         miso_o <= 1'b1;
         oe_n <= 1'b1;
         load <= 1'b0;
      end else begin
         bcnt <= next_bcnt;
         hdr_done <= next_hdr_done;
         dir <= next_dir;
         sh_in <= next_sh_in;
         sh_out <= next_sh_out;
         reg_addr <= next_reg_addr;
         wr_stb <= next_wr_stb;
         rd_stb <= next_rd_stb;
         fifo_pop <= next_fifo_pop;
         wr_data <= next_wr_data;
         miso_o <= next_miso_o;
         oe_n <= next_oe_n;
         load <= next_load;
      end
   end

   assign link.miso_o = miso_o;
   assign link.miso_oe_n = oe_n;
endmodule : srsp_dev

//--- srsp_host.sv
`timescale 1ns/100ps
module srsp_host
   import srsp_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   srsp_if.host link,
   input wire logic start,
   input wire logic [6:0] addr,
   input wire logic write,
   input wire logic [3:0] words,
   input wire logic [15:0] wdata,
   output logic wdata_take,
   output logic rword_valid,
   output logic [15:0] rword,
   output logic busy
);
   // ==========================================
   // Clock divider and frame sequencer
   logic [1:0] mi_s, next_mi_s;
   srsp_hstate_e st, next_st;
   logic [7:0] div, next_div;
   logic cs_n, next_cs_n, sclk, next_sclk, mosi, next_mosi;
   logic [15:0] sh, next_sh, rsh, next_rsh;
   logic [4:0] bits, next_bits;
   logic hdr, next_hdr;
   logic [3:0] left, next_left;
   logic next_wdata_take, next_rword_valid, next_busy;
   logic [15:0] next_rword;
   logic is_wr, next_is_wr;

   always_comb begin
      next_mi_s = {mi_s[0], link.miso};
      next_st = st;
      next_div = div;
      next_cs_n = cs_n;
      next_sclk = sclk;
      next_mosi = mosi;
      next_sh = sh;
      next_rsh = rsh;
      next_bits = bits;
      next_hdr = hdr;
      next_left = left;
      next_wdata_take = 1'b0;
      next_rword_valid = 1'b0;
      next_rword = rword;
      next_busy = busy;
      next_is_wr = is_wr;
      case (st)
         SRSP_H_IDLE: begin
            next_sclk = 1'b1;
            if (start) begin
               next_cs_n = 1'b0;
               next_sh = {addr, write, 8'h00};
               next_is_wr = write;
               next_left = (words == 4'h0) ? 4'h1 : words;
               next_bits = 5'd8;
               next_hdr = 1'b1;
               next_busy = 1'b1;
               next_div = SRSP_HALF_CNT;
               next_st = SRSP_H_SHIFT;
            end
         end
         SRSP_H_SHIFT: begin
            if (div != 8'h00) begin
               next_div = div - 8'h01;
            end else begin
               next_div = SRSP_HALF_CNT;
               if (sclk) begin
                  // Change data on the falling edge
                  next_sclk = 1'b0;
                  next_mosi = sh[15];
                  next_sh = {sh[14:0], 1'b0};
               end else begin
                  next_sclk = 1'b1;
                  next_rsh = {rsh[14:0], mi_s[1]};
                  next_bits = bits - 5'd1;
                  if (bits == 5'd1) begin
                     if (hdr) begin
                        next_hdr = 1'b0;
                        next_bits = 5'd16;
                        if (is_wr) begin
                           next_sh = wdata;
                           next_wdata_take = 1'b1;
                        end
                     end else begin
                        if (!is_wr) begin
                           next_rword = {rsh[14:0], mi_s[1]};
                           next_rword_valid = 1'b1;
                        end
                        next_left = left - 4'h1;
                        next_bits = 5'd16;
                        if (left == 4'h1) begin
                           next_st = SRSP_H_GAP;
                        end else if (is_wr) begin
                           next_sh = wdata;
                           next_wdata_take = 1'b1;
                        end
                     end
                  end
               end
            end
         end
         SRSP_H_GAP: begin
            if (div != 8'h00) begin
               next_div = div - 8'h01;
            end else begin
               next_cs_n = 1'b1;
               next_busy = 1'b0;
               next_st = SRSP_H_IDLE;
            end
         end
         default: next_st = SRSP_H_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         mi_s <= 2'h3;
         st <= SRSP_H_IDLE;
         div <= 8'h00;
         cs_n <= 1'b1;
         sclk <= 1'b1;
         mosi <= 1'b1;
         sh <= 16'h0000;
         rsh <= 16'h0000;
         bits <= 5'd0;
         hdr <= 1'b0;
         left <= 4'h0;
         wdata_take <= 1'b0;
         rword_valid <= 1'b0;
         rword <= 16'h0000;
         busy <= 1'b0;
         is_wr <= 1'b0;
      end else begin
         mi_s <= next_mi_s;
         st <= next_st;
         div <= next_div;
         cs_n <= next_cs_n;
         sclk <= next_sclk;
         mosi <= next_mosi;
         sh <= next_sh;
         rsh <= next_rsh;
         bits <= next_bits;
         hdr <= next_hdr;
         left <= next_left;
         wdata_take <= next_wdata_take;
         rword_valid <= next_rword_valid;
         rword <= next_rword;
         busy <= next_busy;
         is_wr <= next_is_wr;
      end
   end

   assign link.cs_n = cs_n;
   assign link.sclk = sclk;
   assign link.mosi = mosi;
endmodule : srsp_host

//--- srsp_chk.sv
`timescale 1ns/100ps
module srsp_chk (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic cs_n,
   input wire logic sclk,
   input wire logic mosi,
   input wire logic miso_o,
   input wire logic miso_oe_n,
   input wire logic miso
);
   // ==========
   // Header tracker
   logic [4:0] nbit;
   logic [4:0] next_nbit;
   logic dir;
   logic next_dir;
   logic sclk_q;
   always_comb begin
      next_nbit = nbit;
      next_dir = dir;
      if (cs_n) begin
         next_nbit = 5'h00;
      end else if (sclk && !sclk_q && nbit < 5'h08) begin
         next_nbit = nbit + 5'h01;
         if (nbit == 5'h07) begin
            next_dir = mosi;
         end
      end
   end
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         nbit <= 5'h00;
         dir <= 1'b0;
         sclk_q <= 1'b1;
      end else begin
         nbit <= next_nbit;
         dir <= next_dir;
         sclk_q <= sclk;
      end
   end
   // ==========
   // Properties
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   a_sclk_idle_high: assert property (cs_n |-> sclk)
      else $error("serial clock low outside a frame");
   a_cs_edge_high: assert property ($changed(cs_n) |-> sclk && $past(sclk))
      else $error("select moved while serial clock low");
   a_sclk_half_min: assert property ($changed(sclk) |=> $stable(sclk)[*2])
      else $error("serial clock half period too short");
   a_miso_released: assert property (cs_n[*6] |-> miso_oe_n)
      else $error("data out driven while deselected");
   a_no_drive_write: assert property ((nbit == 5'h08 && dir) |-> miso_oe_n)
      else $error("data out driven in a write frame");
   a_drive_after_read: assert property ($fell(miso_oe_n) |-> !cs_n && nbit == 5'h08 && !dir)
      else $error("data out driven before a read header");
   a_drive_read_bound: assert property ((nbit == 5'h08 && !dir && $fell(sclk)) |-> ##[0:6] !miso_oe_n)
      else $error("data out not driven after read header");
   a_miso_hold_rise: assert property (($rose(sclk) && !cs_n) |-> $stable(miso))
      else $error("data out moved at a rising clock edge");
   c_read_frame: cover property ($fell(miso_oe_n));
   c_write_frame: cover property (nbit == 5'h08 && dir);
   c_frame_end: cover property ($rose(cs_n));
endmodule : srsp_chk

//--- spi_register_slave_port_bench.sv
`timescale 1ns/100ps
module spi_register_slave_port_bench;
   import srsp_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic start = 1'b0;
   logic [6:0] addr = 7'h00;
   logic write = 1'b0;
   logic [3:0] words = 4'h1;
   logic [15:0] wdata = 16'h0000;
   logic [15:0] rd_data = 16'h0000;
   logic [6:0] reg_addr, reg_addr_b, pa;
   logic [15:0] wr_data, wr_data_b, rword, mw;
   logic wr_stb, wr_stb_b, rd_stb, fifo_pop, wdata_take, rword_valid, busy;
   logic [22:0] wq[$];
   logic [15:0] rq[$];
   logic [15:0] wv[4] = '{16'h1234, 16'hbeef, 16'h0f0f, 16'hc3a5};
   logic [23:0] ws;
   logic [15:0] ms;
   logic [7:0] hdr;
   int n_mismatch = 0, n_tests = 0, pops = 0, wi = 0, nb = 0, stb_b = 0, rds = 0;
   srsp_if lk();
   srsp_if lk2();
   srsp_host u_srsp_host (.clk(clk), .rst_n(rst_n), .link(lk), .start(start), .addr(addr),
      .write(write), .words(words), .wdata(wdata), .wdata_take(wdata_take),
      .rword_valid(rword_valid), .rword(rword), .busy(busy));
   srsp_dev u_srsp_dev (.clk(clk), .rst_n(rst_n), .link(lk), .reg_addr(reg_addr),
      .wr_stb(wr_stb), .wr_data(wr_data), .rd_stb(rd_stb), .fifo_pop(fifo_pop), .rd_data(rd_data));
   // Second device is driven by hand so a frame can be cut short
   srsp_dev u_srsp_dev_b (.clk(clk), .rst_n(rst_n), .link(lk2), .reg_addr(reg_addr_b),
      .wr_stb(wr_stb_b), .wr_data(wr_data_b), .rd_stb(), .fifo_pop(), .rd_data(16'h0000));
   srsp_chk u_srsp_chk (.clk(clk), .rst_n(rst_n), .cs_n(lk.cs_n), .sclk(lk.sclk), .mosi(lk.mosi),
      .miso_o(lk.miso_o), .miso_oe_n(lk.miso_oe_n), .miso(lk.miso));
   always #10 clk = ~clk;
   // ==========
   // Models and monitors
   function automatic logic [15:0] mem(input logic [6:0] a);
      return {a, 9'h0a5};
   endfunction : mem
   always @(negedge clk) begin
      rd_data <= mem(reg_addr);
      if (wr_stb === 1'b1) wq.push_back({pa, wr_data});
      if (rword_valid === 1'b1) rq.push_back(rword);
      if (fifo_pop === 1'b1) pops++;
      if (rd_stb === 1'b1) rds++;
      if (wr_stb_b === 1'b1) stb_b++;
      if (wdata_take === 1'b1) begin
         wi++;
         wdata = wv[wi % 4];
      end
      pa = reg_addr;
   end
   always @(negedge lk.cs_n) nb = 0;
   always @(posedge lk.sclk) if (lk.cs_n === 1'b0) begin
      ws = {ws[22:0], lk.mosi};
      ms = {ms[14:0], lk.miso};
      nb++;
      if (nb == 8) hdr = ws[7:0];
      if (nb == 24) mw = ms;
   end
   // ==========
   // Tasks
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic burst(input logic [6:0] a, input logic w, input logic [3:0] n);
      int t;
      logic [6:0] ea;
      t = 0;
      ea = a;
      wq.delete();
      rq.delete();
      pops = 0;
      rds = 0;
      @(negedge clk);
      addr = a;
      write = w;
      words = n;
      wi = 0;
      wdata = wv[0];
      start = 1'b1;
      @(negedge clk);
      start = 1'b0;
      while (busy !== 1'b0 && t < 3000) begin
         @(negedge clk);
         t++;
      end
      repeat (10) @(negedge clk);
      chk("done", 0, t >= 3000);
      chk("header", {a, w}, hdr);
      chk("strobes", w ? n : 0, wq.size());
      chk("words", w ? 0 : n, rq.size());
      chk("pops", (a == 7'h60 && !w) ? n : 0, pops);
      chk("fetches", w ? 0 : n + 1, rds);
      if (!w) chk("wire word", mem(a), mw);
      for (int i = 0; i < n; i++) begin
         if (w) chk("write", {ea, wv[i]}, wq[i]);
         else chk("read", mem(ea), rq[i]);
         if (ea != 7'h5f && ea != 7'h60 && ea != 7'h7f) ea = ea + 7'h01;
      end
   endtask : burst
   task automatic bang(input logic [23:0] b, input int n);
      lk2.cs_n = 1'b0;
      for (int i = 0; i < n; i++) begin
         repeat (4) @(negedge clk);
         lk2.sclk = 1'b0;
         lk2.mosi = b[23-i];
         repeat (4) @(negedge clk);
         lk2.sclk = 1'b1;
      end
      repeat (4) @(negedge clk);
      lk2.cs_n = 1'b1;
      lk2.mosi = ~lk2.mosi;
      repeat (20) @(negedge clk);
   endtask : bang
   task automatic close_out;
      $display("Comparisons %0d, mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : close_out
   // ==========
   // Sequence
   initial begin
      // Several times the expected run length
      #400_000;
      n_mismatch++;
      close_out();
   end
   initial begin
      lk2.cs_n = 1'b1;
      lk2.sclk = 1'b1;
      lk2.mosi = 1'b1;
      repeat (4) @(negedge clk);
      rst_n = 1'b1;
      burst(7'h5e, 1'b1, 4'h3);
      burst(7'h7e, 1'b0, 4'h3);
      burst(7'h60, 1'b0, 4'h3);
      burst(7'h60, 1'b1, 4'h2);
      burst(7'h10, 1'b0, 4'h1);
      burst(7'h2a, 1'b1, 4'h4);
      bang({7'h21, 1'b1, 16'ha5ff}, 16);
      chk("cut write", 0, stb_b);
      bang({7'h21, 1'b1, 16'h5a3c}, 24);
      chk("full write", 1, stb_b);
      chk("full data", 16'h5a3c, wr_data_b);
      chk("next addr", 7'h22, reg_addr_b);
      close_out();
   end
endmodule : spi_register_slave_port_bench
